// ---- bench/spi_host_model.sv ----
// Behavioural host that faces the serial pins of the block
module spi_host_model (
    // Mode and straps set by the bench
    input wire logic i2c,
    input wire logic strap0,
    input wire logic strap1,
    // Device side of the two-way pins
    input wire logic data_out,
    input wire logic data_oe,
    input wire logic a1_out,
    input wire logic a1_oe,
    // Wire levels handed to the device
    output logic sclk,
    output logic data_wire,
    output logic a1_wire,
    output logic a0_wire
);
    timeunit 1ns;
    timeprecision 100ps;
    // ========================================================
    // Pin state
    logic sel_n = 1'b1; // Host select, idle high
    logic drv = 1'b0; // Host drives the data pin
    logic bit_h = 1'b0; // Host data value
    logic last = 1'b0; // Last level seen on the data pin
    logic [7:0] rd_byte = 8'h00; // Byte read back
    event done; // Fires after each read frame

    // device wins the pin; released pin shows no stale value
    assign data_wire = data_oe ? data_out : (drv ? bit_h : ~last);
    // strap unless the device drives read data
    assign a1_wire = a1_oe ? a1_out : strap1;
    // strap in I2C, host select in SPI
    assign a0_wire = i2c ? strap0 : sel_n;

    // Keeps the inverse value fresh on each serial clock rise inside a frame
    always @(posedge sclk) begin
        last <= data_wire;
    end

    // one frame; clock only runs inside it, 6 ns period
    task automatic frame(input logic [7:0] cmd, input logic three,
                         input logic sel_ok);
        int n;
        n = cmd[7] ? 16 : 8;
        sel_n = ~sel_ok;
        #2;
        for (int i = 0; i < n; i++) begin
            drv = (i < 8);
            bit_h = (i < 8) ? cmd[7-(i%8)] : 1'b0;
            #1.5 sclk = 1'b1;
            #3 sclk = 1'b0;
            // host lets go after the last command bit is taken
            if (i >= 7) begin
                drv = 1'b0;
            end
            if (cmd[7] && i >= 7 && i < 15) begin
                rd_byte[14-i] = three ? data_wire : a1_wire;
            end
            #1.5;
        end
        sel_n = 1'b1;
        #2;
        if (cmd[7]) begin
            ->done;
        end
    endtask

    initial begin
        sclk = 1'b0;
    end
endmodule

// ---- bench/tb.sv ----
// Self-checking bench of the host pin and status output block
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import pin_ctrl_pkg::*;
    // ========================================================
    // Stimulus and observation
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic i2c_sel = 1'b1; // Mode strap
    logic three = 1'b0; // SPI wiring choice
    logic s0 = 1'b0; // Address strap bit 0
    logic s1 = 1'b0; // Address strap bit 1
    logic rst_pin_n = 1'b1;
    logic odis = 1'b0;
    logic locked = 1'b0;
    logic [NUM_INPUTS-1:0] present = 4'h0;
    logic sclk, d_wire, a1_wire, a0_wire, d_out, d_oe, a1_out, a1_oe;
    logic irq_n, unl_n, coe, mode;
    logic [3:0] lost_n;
    logic [1:0] addr;
    logic [4:0] pend = 5'h00; // Expected pending events
    logic [21:0] oq[$]; // Notes of {care mask, pin levels}
    logic [7:0] rq[$]; // Notes of read bytes
    logic [21:0] e;
    logic [4:0] ev; // Random status for the next step
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    wire [10:0] obs = {irq_n, unl_n, lost_n, coe, mode, addr, a1_oe | d_oe};

    host_pins_and_status_outputs u_dut (
        .clock(clock), .sys_rst(sys_rst), .sclk(sclk),
        .i2c_sel(i2c_sel), .spi_three_wire(three),
        .serial_data_in(d_wire), .serial_data_out(d_out),
        .serial_data_oe(d_oe), .addr_bit1_or_serial_out_in(a1_wire),
        .addr_bit1_or_serial_out_out(a1_out),
        .addr_bit1_or_serial_out_oe(a1_oe),
        .addr_bit0_or_chip_select_n(a0_wire),
        .device_reset_n(rst_pin_n), .output_disable_pin(odis),
        .pll_locked(locked), .clock_present(present),
        .status_change_irq_n(irq_n), .pll_unlock_n(unl_n),
        .input0_clock_lost_n(lost_n[0]), .input1_clock_lost_n(lost_n[1]),
        .input2_clock_lost_n(lost_n[2]), .input3_clock_lost_n(lost_n[3]),
        .clock_outputs_enable(coe), .i2c_mode(mode), .i2c_slave_addr(addr)
    );

    spi_host_model u_host (
        .i2c(i2c_sel), .strap0(s0), .strap1(s1), .data_out(d_out),
        .data_oe(d_oe), .a1_out(a1_out), .a1_oe(a1_oe), .sclk(sclk),
        .data_wire(d_wire), .a1_wire(a1_wire), .a0_wire(a0_wire)
    );

    // ========================================================
    // Clock, timeout and checking
    always #25 clock = ~clock;

    // Cuts a hang short well past the expected run
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Pin notes are compared just after the edge that follows them
    always @(posedge clock) begin
        if (oq.size() > 0) begin
            #1;
            e = oq.pop_front();
            check(obs & e[21:11], e[10:0] & e[21:11]);
        end
    end

    // Read bytes are compared as each read frame closes
    always @(u_host.done) begin
        check({3'h0, u_host.rd_byte}, {3'h0, rq.pop_front()});
    end

    // Settle, then note the levels that the live inputs call for
    task automatic expect_pins(input logic irq, input logic [10:0] care);
        repeat (6) @(negedge clock);
        oq.push_back({care, irq, locked, present, ~odis, i2c_sel, s1, s0,
                      1'b0});
        @(posedge clock);
        #2;
        @(negedge clock);
    endtask

    task automatic give_verdict();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ========================================================
    // Main sequence
    initial begin
        void'($urandom(5));
        repeat (6) @(negedge clock);
        // reset levels on every status pin
        oq.push_back({11'h7ff, 11'h400});
        repeat (2) @(negedge clock);
        sys_rst = 1'b0;
        // Test 1: straps give the I2C address, nothing driven
        s0 = 1'($urandom);
        s1 = 1'($urandom);
        expect_pins(1'b1, 11'h7ff);
        $display("test 1 done");
        // Test 2: disable pin both ways
        for (int v = 1; v >= 0; v--) begin
            odis = 1'(v);
            expect_pins(1'b1, 11'h7ff);
        end
        $display("test 2 done");
        // Test 3: random status changes raise the interrupt
        for (int k = 0; k < 3; k++) begin
            ev = 5'($urandom_range(1, 31));
            pend = pend | (ev ^ {present, locked});
            {present, locked} = ev;
            expect_pins(~|pend, 11'h7ff);
        end
        // A clear frame in I2C mode must leave the pending bits alone
        u_host.frame(8'h1f, 1'b0, 1'b1);
        $display("test 3 done");
        // Test 4: SPI reads of the pending byte on both wirings
        i2c_sel = 1'b0;
        repeat (4) @(negedge clock);
        u_host.frame(8'h00, 1'b0, 1'b1);
        for (int k = 0; k < 2; k++) begin
            three = 1'(k);
            rq.push_back({3'h0, pend});
            u_host.frame(8'h80, three, 1'b1);
        end
        expect_pins(1'b0, 11'h7f9);
        $display("test 4 done");
        // Test 5: clocks without select change nothing, then clear
        u_host.frame(8'h1f, 1'b0, 1'b0);
        expect_pins(1'b0, 11'h7f9);
        u_host.frame({3'h0, pend}, 1'b0, 1'b1);
        pend = 5'h00;
        expect_pins(1'b1, 11'h7f9);
        $display("test 5 done");
        // Test 6: reset pin restores defaults, live status re-arms
        rst_pin_n = 1'b0;
        repeat (6) @(negedge clock);
        oq.push_back({11'h7ff, 11'h400});
        repeat (2) @(negedge clock);
        rst_pin_n = 1'b1;
        pend = {present, locked};
        expect_pins(~|pend, 11'h7f9);
        $display("test 6 done");
        give_verdict();
    end
endmodule

// ---- rtl/bit_sync2.sv ----
// Two flip-flop level synchroniser, one stage pair per bit
module bit_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and synchronous reset of the receiving domain
    input wire logic clock,
    input wire logic sys_rst,
    // Level from another domain or a pin
    input wire logic [WIDTH-1:0] async_in,
    // Level safe to read in this domain
    output logic [WIDTH-1:0] sync_out
);

    // ========================================================
    // State
    // Meta stage is read by the stable stage only
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    // Registered and next state
    sync_state_t s;
    sync_state_t next_s;

    // Shift one stage per edge
    always_comb begin
        next_s.meta = async_in;
        next_s.stable = s.meta;
    end

    // Registers, cleared by reset
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Only the second stage leaves the module
    assign sync_out = s.stable;

endmodule

// ---- rtl/host_pins_and_status_outputs.sv ----
// Host pins, serial select logic and status outputs of the clock device
module host_pins_and_status_outputs (
    // System clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Serial clock from the host, its own domain
    input wire logic sclk,
    // Serial mode strap and SPI wiring choice
    input wire logic i2c_sel,
    input wire logic spi_three_wire,
    // Two-way serial data pin
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe,
    // Address bit 1 strap or SPI read data pin
    input wire logic addr_bit1_or_serial_out_in,
    output logic addr_bit1_or_serial_out_out,
    output logic addr_bit1_or_serial_out_oe,
    // Address bit 0 strap or SPI select pin
    input wire logic addr_bit0_or_chip_select_n,
    // Control pins
    input wire logic device_reset_n,
    input wire logic output_disable_pin,
    // Status from the analog core
    input wire logic pll_locked,
    input wire logic [pin_ctrl_pkg::NUM_INPUTS-1:0] clock_present,
    // Status pins
    output logic status_change_irq_n,
    output logic pll_unlock_n,
    output logic input0_clock_lost_n,
    output logic input1_clock_lost_n,
    output logic input2_clock_lost_n,
    output logic input3_clock_lost_n,
    // Controls to the rest of the device
    output logic clock_outputs_enable,
    output logic i2c_mode,
    output logic [1:0] i2c_slave_addr
);
    import pin_ctrl_pkg::*;

    // ========================================================
    // System domain synchronisers
    // Width of the bundle of pins brought into the system clock
    localparam int SYS_SYNC_W = NUM_INPUTS + 7;

    // Raw pins and the link toggle, then their synced copies
    logic [SYS_SYNC_W-1:0] sys_raw;
    logic [SYS_SYNC_W-1:0] sys_synced;
    // Named views of the synced bundle
    logic dev_rst_s;
    logic disable_s;
    logic mode_s;
    logic addr1_s;
    logic addr0_s;
    logic locked_s;
    logic clear_tog_s;
    logic [NUM_INPUTS-1:0] present_s;
    // Link side handoff, read in the system domain
    logic clear_tog;
    logic [NUM_STAT-1:0] clear_mask;

    // Bundle the asynchronous levels
    assign sys_raw = {clock_present, clear_tog, pll_locked,
                      addr_bit0_or_chip_select_n,
                      addr_bit1_or_serial_out_in, i2c_sel,
                      output_disable_pin, device_reset_n};

    bit_sync2 #(
        .WIDTH(SYS_SYNC_W)
    ) u_sys_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in(sys_raw),
        .sync_out(sys_synced)
    );

    // Unpack the bundle
    assign {present_s, clear_tog_s, locked_s, addr0_s, addr1_s,
            mode_s, disable_s, dev_rst_s} = sys_synced;

    // ========================================================
    // System domain state
    typedef struct packed {
        logic [NUM_STAT-1:0] sticky;    // Pending status changes
        logic [NUM_STAT-1:0] prev_live; // Status seen last cycle
        logic irq_n;                    // Interrupt pin level
        logic lock_out;                 // Lock pin level
        logic [NUM_INPUTS-1:0] lost_n;  // Per-input loss pins
        logic out_en;                   // Clock outputs allowed
        logic mode;                     // I2C selected
        logic [1:0] addr;               // Strapped slave address
        logic seen_tog;                 // Last clear toggle taken
    } sys_state_t;

    // Reset image: outputs off, interrupt idle
    localparam sys_state_t SYS_RESET = '{
        sticky: '0, prev_live: '0, irq_n: 1'b1, lock_out: 1'b0,
        lost_n: '0, out_en: 1'b0, mode: 1'b0, addr: 2'h0,
        seen_tog: 1'b0};

    sys_state_t s;
    sys_state_t next_s;
    // Current live status word and clear request
    logic [NUM_STAT-1:0] live;
    logic [NUM_STAT-1:0] clear_now;

    // Next system state
    always_comb begin
        next_s = s;
        live = '0;
        live[STAT_LOCK_BIT] = locked_s;
        live[STAT_LOST_BASE +: NUM_INPUTS] = present_s;
        // Mask is held still by the link until the toggle is taken
        clear_now = (clear_tog_s != s.seen_tog) ? clear_mask : '0;
        next_s.seen_tog = clear_tog_s;
        next_s.prev_live = live;
        next_s.sticky = (s.sticky & ~clear_now) | (live ^ s.prev_live);
        next_s.irq_n = ~(|next_s.sticky);
        next_s.lock_out = locked_s;
        next_s.lost_n = present_s;
        next_s.out_en = ~disable_s;
        next_s.mode = (mode_s == MODE_I2C);
        next_s.addr = {addr1_s, addr0_s};
    end

    always_ff @(posedge clock) begin
        if (sys_rst || !dev_rst_s) begin
            s <= SYS_RESET;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the system registers
    assign status_change_irq_n = s.irq_n;
    assign pll_unlock_n = s.lock_out;
    assign input0_clock_lost_n = s.lost_n[0];
    assign input1_clock_lost_n = s.lost_n[1];
    assign input2_clock_lost_n = s.lost_n[2];
    assign input3_clock_lost_n = s.lost_n[3];
    assign clock_outputs_enable = s.out_en;
    assign i2c_mode = s.mode;
    assign i2c_slave_addr = s.addr;

    // ========================================================
    // Link domain synchronisers
    // Mode straps and pending bits brought onto the serial clock
    localparam int LINK_SYNC_W = NUM_STAT + 2;
    logic [LINK_SYNC_W-1:0] link_raw;
    logic [LINK_SYNC_W-1:0] link_synced;
    logic spi_l;
    logic three_wire_l;
    logic [NUM_STAT-1:0] sticky_l;

    // Pending bits change slowly and are only read as a snapshot
    assign link_raw = {s.sticky, spi_three_wire, ~i2c_sel};

    // Serial clock only runs in frames, so no reset is possible
    bit_sync2 #(
        .WIDTH(LINK_SYNC_W)
    ) u_link_sync (
        .clock(sclk),
        .sys_rst(1'b0),
        .async_in(link_raw),
        .sync_out(link_synced)
    );

    assign {sticky_l, three_wire_l, spi_l} = link_synced;

    // ========================================================
    // Link frame state, cleared while select is high
    typedef struct packed {
        link_state_t state;      // Frame phase
        logic [CNT_W-1:0] cnt;   // Edges seen in this frame
        logic [CMD_BITS-1:0] cmd;   // Command shift register
        logic [CMD_BITS-1:0] shift; // Read data shift register
        logic out_bit;           // Read bit on the pins
        logic data_oe;           // Drive the two-way data pin
        logic serial_oe;         // Drive the address 1 pin
    } link_state_frame_t;

    localparam link_state_frame_t LINK_RESET = '{
        state: LINK_CMD, cnt: '0, cmd: '0, shift: '0,
        out_bit: 1'b0, data_oe: 1'b0, serial_oe: 1'b0};
    // Handoff to the system domain, never cleared by select
    typedef struct packed {
        logic tog;                  // Flips once per clear
        logic [NUM_STAT-1:0] mask;  // Bits to clear
    } link_handoff_t;
    link_state_frame_t f;
    link_state_frame_t next_f;
    link_handoff_t h;
    link_handoff_t next_h;
    // Command byte as it stands after this edge
    logic [CMD_BITS-1:0] cmd_full;
    // Status snapshot for a read
    logic [CMD_BITS-1:0] status_byte;

    // Next link state, one bit per serial clock edge
    always_comb begin
        next_f = f;
        next_h = h;
        cmd_full = {f.cmd[CMD_BITS-2:0], serial_data_in};
        status_byte = CMD_BITS'(sticky_l);
        // nothing happens on the link in I2C mode
        if (!spi_l) begin
            next_f = LINK_RESET;
        end else begin
            case (f.state)
                // Collect the command byte
                LINK_CMD: begin
                    next_f.cmd = cmd_full;
                    next_f.cnt = CNT_W'(f.cnt + CNT_STEP);
                    if (f.cnt == CNT_CMD_LAST) begin
                        if (|cmd_full[NUM_STAT-1:0]) begin
                            next_h.tog = ~h.tog;
                            next_h.mask = cmd_full[NUM_STAT-1:0];
                        end
                        if (cmd_full[CMD_READ_BIT]) begin
                            next_f.state = LINK_READ;
                            next_f.out_bit = status_byte[CMD_BITS-1];
                            next_f.shift = status_byte << 1;
                            // three-wire turns the data pin round
                            next_f.data_oe = three_wire_l;
                            // four-wire drives the address 1 pin
                            next_f.serial_oe = ~three_wire_l;
                        end else begin
                            next_f.state = LINK_DONE;
                        end
                    end
                end
                // Shift the status byte out
                LINK_READ: begin
                    next_f.cnt = CNT_W'(f.cnt + CNT_STEP);
                    next_f.out_bit = f.shift[CMD_BITS-1];
                    next_f.shift = f.shift << 1;
                    if (f.cnt == CNT_FRAME_LAST) begin
                        next_f.state = LINK_DONE;
                        next_f.data_oe = 1'b0;
                        next_f.serial_oe = 1'b0;
                    end
                end
                // Ignore extra edges until select rises
                LINK_DONE: begin
                    next_f.data_oe = 1'b0;
                    next_f.serial_oe = 1'b0;
                end
                default: begin
                    next_f = LINK_RESET;
                end
            endcase
        end
    end

    // select high ends the frame at once
    // reset also clears it, as the serial clock may be stopped
    always_ff @(posedge sclk or posedge addr_bit0_or_chip_select_n
                or negedge dev_rst_s) begin
        if (addr_bit0_or_chip_select_n || !dev_rst_s) begin
            f <= LINK_RESET;
        end else begin
            f <= next_f;
        end
    end
    // Handoff register runs free of select, cleared only by reset
    always_ff @(posedge sclk or negedge dev_rst_s) begin
        if (!dev_rst_s) begin
            h <= '0;
        end else begin
            h <= next_h;
        end
    end
    assign clear_tog = h.tog;
    assign clear_mask = h.mask;
    // Pin drivers straight from the frame registers
    assign serial_data_out = f.out_bit;
    assign serial_data_oe = f.data_oe;
    assign addr_bit1_or_serial_out_out = f.out_bit;
    assign addr_bit1_or_serial_out_oe = f.serial_oe;

    // ========================================================
    // Checks
    AST_IRQ_PENDING: assert property (@(posedge clock)
        disable iff (sys_rst || !dev_rst_s)
        (live != s.prev_live) |=> !status_change_irq_n)
        else $error("Status change did not raise interrupt");
    AST_LOCK_EVENT: assert property (@(posedge clock)
        disable iff (sys_rst || !dev_rst_s)
        ($changed(locked_s) && $past(dev_rst_s) && dev_rst_s)
        |=> !status_change_irq_n)
        else $error("Lock change did not raise interrupt");
    AST_IRQ_HOLDS: assert property (@(posedge clock)
        disable iff (sys_rst || !dev_rst_s)
        (!status_change_irq_n && clear_tog_s == s.seen_tog)
        |=> !status_change_irq_n)
        else $error("Interrupt released without a clear");
    AST_RESET_OFF: assert property (@(posedge clock)
        (sys_rst || !dev_rst_s) |=>
        (!clock_outputs_enable && status_change_irq_n && !(|s.sticky)))
        else $error("Reset did not clear state and outputs");
    AST_DISABLE_PIN: assert property (@(posedge clock)
        disable iff (sys_rst || !dev_rst_s)
        disable_s ##1 (!sys_rst && dev_rst_s) |-> !clock_outputs_enable)
        else $error("Outputs enabled while disable pin high");
    AST_LOCK_PIN: assert property (@(posedge clock)
        disable iff (sys_rst || !dev_rst_s)
        $past(dev_rst_s) |-> pll_unlock_n == $past(locked_s))
        else $error("Lock pin does not follow lock state");
    AST_LOST_PINS: assert property (@(posedge clock)
        disable iff (sys_rst || !dev_rst_s)
        $past(dev_rst_s) |-> {input3_clock_lost_n, input2_clock_lost_n,
        input1_clock_lost_n, input0_clock_lost_n} == $past(present_s))
        else $error("Loss pins do not follow input presence");
    AST_ADDR_STRAP: assert property (@(posedge clock)
        disable iff (sys_rst || !dev_rst_s)
        $past(dev_rst_s) |-> i2c_slave_addr == $past({addr1_s, addr0_s}))
        else $error("Slave address does not follow straps");
    AST_I2C_NO_DRIVE: assert property (@(posedge sclk)
        !spi_l |=> !addr_bit1_or_serial_out_oe && !serial_data_oe)
        else $error("Pin driven in I2C mode");
    AST_READ_DRIVE: assert property (@(posedge sclk)
        disable iff (addr_bit0_or_chip_select_n)
        (f.state == LINK_READ) |->
        (addr_bit1_or_serial_out_oe == !three_wire_l
         && serial_data_oe == three_wire_l))
        else $error("Read data on the wrong pin");
    AST_SELECT_IDLE: assert property (@(posedge clock)
        addr_bit0_or_chip_select_n |->
        !addr_bit1_or_serial_out_oe && !serial_data_oe)
        else $error("Pin driven while deselected");

    // Main scenarios
    COV_READ_FOUR: cover property (@(posedge sclk)
        f.state == LINK_READ && f.serial_oe);
    COV_READ_THREE: cover property (@(posedge sclk)
        f.state == LINK_READ && f.data_oe);
    COV_IRQ_CLEARED: cover property (@(posedge clock)
        !status_change_irq_n ##1 status_change_irq_n);
    COV_DISABLED: cover property (@(posedge clock)
        clock_outputs_enable ##1 !clock_outputs_enable);

endmodule

// ---- rtl/pin_ctrl_pkg.sv ----
// Shared constants and types of the host pin and status output block
package pin_ctrl_pkg;

    // ========================================================
    // Sizes
    // Number of monitored clock inputs
    localparam int NUM_INPUTS = 4;
    // Sticky status bits: lock change plus one per input
    localparam int NUM_STAT = NUM_INPUTS + 1;
    // Position of the lock-change bit in the status word
    localparam int STAT_LOCK_BIT = 0;
    // First position of the per-input loss bits
    localparam int STAT_LOST_BASE = 1;

    // ========================================================
    // Serial frame layout
    // Command byte length, shifted in MSB first
    localparam int CMD_BITS = 8;
    // Command bit that asks for the status byte back
    localparam int CMD_READ_BIT = 7;
    // Bit counter width, covers a whole frame
    localparam int CNT_W = 5;
    // Counter value on the last command edge
    localparam logic [CNT_W-1:0] CNT_CMD_LAST = 5'h07;
    // Counter value on the last read edge
    localparam logic [CNT_W-1:0] CNT_FRAME_LAST = 5'h0f;
    // Counter step
    localparam logic [CNT_W-1:0] CNT_STEP = 5'h01;

    // ========================================================
    // Mode pin levels
    // Mode strap level that selects I2C
    localparam logic MODE_I2C = 1'b1;

    // ========================================================
    // Link frame states, Gray coded along a read frame; a write frame steps from 00 to 11
    typedef enum logic [1:0] {
        LINK_CMD = 2'b00,
        LINK_READ = 2'b01,
        LINK_DONE = 2'b11
    } link_state_t;

endpackage
